// ===== sram_ctl_pkg.sv
// Package for the 64K x 1 asynchronous static memory controller.
// Assumes a 50 MHz system clock; all pin timing derives from it.
package sram_ctl_pkg;

	localparam int ADDR_W      = 16;
	localparam int CLK_PERIOD_NS = 20;

	// Pin timing of the memory, in nanoseconds.
	localparam int ACCESS_NS          = 20;
	localparam int CYCLE_NS           = 20;
	localparam int WRITE_STROBE_NS    = 17;
	localparam int SELECT_TO_END_NS   = 12;
	localparam int ADDR_TO_END_NS     = 17;
	localparam int WRITE_DATA_SETUP_NS = 13;

	// Least times round up to whole clock cycles.
	localparam int ACCESS_CYC =
		(ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_CYC_A =
		(WRITE_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_CYC_B =
		(ADDR_TO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_CYC = (WRITE_CYC_A > WRITE_CYC_B) ?
		WRITE_CYC_A : WRITE_CYC_B;
	localparam int GAP_CYC =
		(CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [1:0] CNT_RESET = 2'h0;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_RSET  = 3'b001,
		ST_READ  = 3'b010,
		ST_WSET  = 3'b011,
		ST_WRITE = 3'b100,
		ST_GAP   = 3'b101
	} state_t;

endpackage

// ===== pin_bus_if.sv
// Interface carrying the memory pin group between the controller and its
// pin register stage. Assumes one clock domain.
`timescale 1ns/10ps
interface pin_bus_if;
	logic [15:0] addr;
	logic        select_n;
	logic        write_n;
	logic        wdata;

	modport src (output addr, output select_n, output write_n,
		output wdata);
	modport dst (input addr, input select_n, input write_n, input wdata);
endinterface

// ===== pin_regs.sv
// Output flip-flops for the memory pins, so every pin comes glitch free.
// Assumes the memory sees pins one clock after the controller decides.
`timescale 1ns/10ps
module pin_regs
	import sram_ctl_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              sys_rst_in,
	pin_bus_if.dst                 pins,
	output logic      [ADDR_W-1:0] mem_addr_out,
	output logic                   mem_select_n_out,
	output logic                   mem_write_n_out,
	output logic                   mem_wdata_out
);

	// Reset parks the memory deselected, so it sits in standby.
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mem_addr_out     <= '0;
			mem_select_n_out <= 1'b1;
			mem_write_n_out  <= 1'b1;
			mem_wdata_out    <= 1'b0;
		end else begin
			mem_addr_out     <= pins.addr;
			mem_select_n_out <= pins.select_n;
			mem_write_n_out  <= pins.write_n;
			mem_wdata_out    <= pins.wdata;
		end
	end

endmodule

// ===== sram_ctl.sv
// Host controller for a 64K x 1 asynchronous static memory with split
// data-in and data-out pins. A user issues one read or write at a time.
// Assumes the memory pins are wired directly and rdata input is synchronous.
//
// Notes on behaviour
// - Read: select low, write strobe high
// - Select low 12 ns before write end
// - Address valid at write start
// - Address stable 17 ns before write end
// - Address held until write has ended
// - Write strobe low 17 ns minimum
// - Data setup 13 ns, zero hold
// - Retention needs select held high
// - Write is overlap; first rise ends it
// - Select or strobe high while address moves
`timescale 1ns/10ps
module sram_ctl
	import sram_ctl_pkg::*;
(
	input  wire logic              clk_in,
	input  wire logic              sys_rst_in,
	input  wire logic              req_valid_in,
	input  wire logic              req_write_in,
	input  wire logic [ADDR_W-1:0] req_addr_in,
	input  wire logic              req_wdata_in,
	output logic                   req_ready_out,
	output logic                   rsp_valid_out,
	output logic                   rsp_rdata_out,
	output logic      [ADDR_W-1:0] mem_addr_out,
	output logic                   mem_select_n_out,
	output logic                   mem_write_n_out,
	output logic                   mem_wdata_out,
	input  wire logic              mem_rdata_in
);

	// ****************************************************************
	// State and request capture
	// ****************************************************************

	state_t            state_q;
	logic        [1:0] cnt_q;
	logic [ADDR_W-1:0] addr_q;
	logic              wdata_q;
	logic              is_write_q;
	logic              step_done;

	pin_bus_if pins ();

	function automatic logic cnt_done(input logic [1:0] cnt,
		input int limit);
		cnt_done = (32'(cnt) + 1 >= limit);
	endfunction

	assign req_ready_out = (state_q == ST_IDLE);

	// The address and data are latched once and held for the whole cycle,
	// so nothing moves while select and strobe are both low.
	// address first
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			addr_q     <= '0;
			wdata_q    <= 1'b0;
			is_write_q <= 1'b0;
		end else if (req_valid_in && req_ready_out) begin
			addr_q     <= req_addr_in;
			wdata_q    <= req_wdata_in;
			is_write_q <= req_write_in;
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************

	// A setup state puts address and data out with both strobes high
	// for one cycle before any strobe falls, which also keeps the address
	// steady around every strobe edge.
	// address moves deselected
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (req_valid_in) begin
						state_q <= req_write_in ? ST_WSET : ST_RSET;
					end
				end
				ST_RSET: begin
					state_q <= ST_READ;
				end
				ST_READ: begin
					if (step_done) begin
						state_q <= ST_GAP;
					end
				end
				ST_WSET: begin
					state_q <= ST_WRITE;
				end
				ST_WRITE: begin
					if (step_done) begin
						state_q <= ST_GAP;
					end
				end
				ST_GAP: begin
					if (step_done) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Step timing
	// ****************************************************************

	// Timed states end when their count reaches the least number of
	// cycles, READ one cycle more for the pin lag; every other state but IDLE lasts a single cycle.
	always_comb begin
		step_done = 1'b1;
		unique case (state_q)
			ST_READ:  step_done = cnt_done(cnt_q, ACCESS_CYC + 1);
			ST_WRITE: step_done = cnt_done(cnt_q, WRITE_CYC);
			ST_GAP:   step_done = cnt_done(cnt_q, GAP_CYC);
			default:  step_done = 1'b1;
		endcase
	end

	// Two bits cover every limit at this clock; a slower speed grade or a
	// faster clock needs a wider counter, or the counts would wrap.
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cnt_q <= CNT_RESET;
		end else if (step_done) begin
			cnt_q <= CNT_RESET;
		end else begin
			cnt_q <= cnt_q + 2'h1;
		end
	end

	// ****************************************************************
	// Pin drive
	// ****************************************************************

	assign pins.addr  = addr_q;
	assign pins.wdata = wdata_q;
	assign pins.select_n = !(state_q == ST_READ || state_q == ST_WRITE);
	assign pins.write_n = !(state_q == ST_WRITE);

	// Both strobes rise on the same edge, so the write ends cleanly and
	// the address is changed only in a later cycle with select high.
	// address hold
	pin_regs u_pin_regs (
		.clk_in           (clk_in),
		.sys_rst_in       (sys_rst_in),
		.pins             (pins),
		.mem_addr_out     (mem_addr_out),
		.mem_select_n_out (mem_select_n_out),
		.mem_write_n_out  (mem_write_n_out),
		.mem_wdata_out    (mem_wdata_out)
	);

	// ****************************************************************
	// Read return
	// ****************************************************************

	// The pins lag the state by one cycle, so the last READ cycle sits a
	// full access time after select fell at the memory.
	// read sample
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rsp_valid_out <= 1'b0;
		end else begin
			rsp_valid_out <= (state_q == ST_READ) && step_done;
		end
	end

	// The bit stays until the next read, so a slow user can still take
	// it after the one-cycle valid pulse has gone.
	// data after access
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rsp_rdata_out <= 1'b0;
		end else if ((state_q == ST_READ) && step_done) begin
			rsp_rdata_out <= mem_rdata_in;
		end
	end

endmodule

// ===== sram_ctl_asserts.sv
// Checker of the controller's pin and request timing.
// Assumes it is bound to sram_ctl and sees only its ports.
`timescale 1ns/10ps
module sram_ctl_asserts
	import sram_ctl_pkg::*;
(
	input wire logic              clk_in,
	input wire logic              sys_rst_in,
	input wire logic              req_valid_in,
	input wire logic              req_write_in,
	input wire logic              req_ready_out,
	input wire logic              rsp_valid_out,
	input wire logic [ADDR_W-1:0] mem_addr_out,
	input wire logic              mem_select_n_out,
	input wire logic              mem_write_n_out,
	input wire logic              mem_wdata_out
);
	// ****************
	// Pin and request properties
	// ****************
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);
	sequence read_taken;
		req_valid_in && req_ready_out && !req_write_in;
	endsequence
	sequence strobe_pulse;
		$fell(mem_write_n_out) ##1 mem_write_n_out;
	endsequence
	sel_write_a: assert property (
		!mem_write_n_out |-> !mem_select_n_out) else $error("bad strobe");
	write_pulse_a: assert property (
		$fell(mem_write_n_out) |-> strobe_pulse) else $error("bad pulse");
	addr_hold_a: assert property (
		!mem_select_n_out && !$past(mem_select_n_out) |->
		$stable(mem_addr_out)) else $error("address moved");
	wdata_hold_a: assert property (
		!mem_write_n_out |-> $stable(mem_wdata_out)) else $error("data moved");
	read_lat_a: assert property (
		read_taken |-> ##4 rsp_valid_out) else $error("late read");
	addr_move_a: assert property (
		$changed(mem_addr_out) |->
		mem_select_n_out && $past(mem_select_n_out))
		else $error("address moved while selected");
	rsp_pulse_a: assert property (
		rsp_valid_out |=> !rsp_valid_out) else $error("long response");
	read_mode_a: assert property (
		$rose(rsp_valid_out) |->
		!$past(mem_select_n_out) && $past(mem_write_n_out))
		else $error("bad read");
	idle_desel_a: assert property (
		req_ready_out |-> mem_select_n_out) else $error("selected in idle");
endmodule
bind sram_ctl sram_ctl_asserts u_chk (.clk_in(clk_in),
	.sys_rst_in(sys_rst_in), .req_valid_in(req_valid_in),
	.req_write_in(req_write_in), .req_ready_out(req_ready_out),
	.rsp_valid_out(rsp_valid_out), .mem_addr_out(mem_addr_out),
	.mem_select_n_out(mem_select_n_out),
	.mem_write_n_out(mem_write_n_out), .mem_wdata_out(mem_wdata_out));

// ===== sram_model.sv
// Behavioural 64K x 1 static memory on the controller's pins.
// Assumes pins change only just after the rising clock edge.
`timescale 1ns/10ps
module sram_model (
	input  wire logic        clk_in,
	input  wire logic [15:0] addr_in,
	input  wire logic        select_n_in,
	input  wire logic        write_n_in,
	input  wire logic        wdata_in,
	output logic             rdata_out
);
	// ****************
	// Storage
	// ****************
	// cells kept
	logic cells [65536];
	logic last_q;
	logic drive;
	initial begin
		last_q = 1'h0;
		foreach (cells[i]) cells[i] = 1'h0;
	end
	assign drive = !select_n_in && write_n_in;
	// floated output shows inverse of last value.
	assign rdata_out = drive ? cells[addr_in] : ~last_q;
	always @(posedge clk_in) begin
		if (!select_n_in && !write_n_in) cells[addr_in] <= wdata_in;
		if (drive) last_q <= cells[addr_in];
	end
endmodule

// ===== tb_sram_ctl.sv
// Self-checking bench for the memory controller.
// Assumes the behavioural memory model stands on the pins.
`timescale 1ns/10ps
module tb_sram_ctl
	import sram_ctl_pkg::*;
;
	// ****************
	// Bench
	// ****************
	typedef struct packed {
		logic              w;
		logic              d;
		logic              e;
		logic [ADDR_W-1:0] a;
	} row_t;
	localparam row_t ROWS [8] = '{'{1'h1,1'h1,1'h0,16'hffff},
		'{1'h1,1'h1,1'h0,16'h0000}, '{1'h1,1'h0,1'h0,16'h0001},
		'{1'h0,1'h0,1'h1,16'hffff}, '{1'h0,1'h0,1'h1,16'h0000},
		'{1'h0,1'h0,1'h0,16'h0001}, '{1'h1,1'h0,1'h0,16'h0000},
		'{1'h0,1'h0,1'h0,16'h0000}};
	logic clk_in, sys_rst_in, req_valid_in, req_write_in, req_wdata_in;
	logic req_ready_out, rsp_valid_out, rsp_rdata_out, mem_rdata_in;
	logic mem_select_n_out, mem_write_n_out, mem_wdata_out;
	logic [ADDR_W-1:0] req_addr_in, mem_addr_out;
	int fails, samples_checked;
	sram_ctl dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.req_valid_in(req_valid_in), .req_write_in(req_write_in),
		.req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
		.req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
		.rsp_rdata_out(rsp_rdata_out), .mem_addr_out(mem_addr_out),
		.mem_select_n_out(mem_select_n_out),
		.mem_write_n_out(mem_write_n_out),
		.mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in));
	sram_model mem (.clk_in(clk_in), .addr_in(mem_addr_out),
		.select_n_in(mem_select_n_out), .write_n_in(mem_write_n_out),
		.wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));
	always #(CLK_PERIOD_NS / 2) clk_in = ~clk_in;
	task automatic chk(input string name, input logic seen, input logic exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic test_done();
		if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Waits at falling edges for ready, or for the response when sel is set.
	task automatic wait_on(input bit sel);
		int n;
		n = 0;
		while ((sel ? rsp_valid_out : req_ready_out) !== 1'h1) begin
			@(negedge clk_in);
			n++;
			if (n > 50) begin
				fails++;
				test_done();
			end
		end
	endtask
	task automatic op(input row_t r);
		wait_on(1'b0);
		{req_write_in, req_wdata_in, req_addr_in} = {r.w, r.d, r.a};
		req_valid_in = 1'h1;
		@(negedge clk_in);
		req_valid_in = 1'h0;
		if (!r.w) begin
			wait_on(1'b1);
			chk("rsp_rdata_out", rsp_rdata_out, r.e);
		end
	endtask
	initial begin
		{clk_in, req_valid_in, req_write_in, req_wdata_in} = 4'h0;
		req_addr_in = 16'h0000;
		sys_rst_in = 1'h1;
		repeat (12) @(posedge clk_in);
		@(negedge clk_in);
		sys_rst_in = 1'h0;
		foreach (ROWS[i]) op(ROWS[i]);
		// A request while busy must leave the memory untouched.
		op('{1'h1,1'h1,1'h0,16'h0002});
		@(negedge clk_in);
		{req_write_in, req_wdata_in, req_addr_in} = {2'h3, 16'h0001};
		req_valid_in = 1'h1;
		@(negedge clk_in);
		req_valid_in = 1'h0;
		op('{1'h0,1'h0,1'h0,16'h0001});
		op('{1'h0,1'h0,1'h1,16'h0002});
		sys_rst_in = 1'h1;
		@(negedge clk_in);
		chk("mem_select_n_out", mem_select_n_out, 1'h1);
		chk("mem_write_n_out", mem_write_n_out, 1'h1);
		chk("rsp_valid_out", rsp_valid_out, 1'h0);
		sys_rst_in = 1'h0;
		op('{1'h0,1'h0,1'h1,16'hffff});
		test_done();
	end
endmodule
